// *** src/sdimb_defines.svh ***
// constants for the synchronous dram command block: mode fields, widths, codes
`ifndef SDIMB_DEFINES_SVH
`define SDIMB_DEFINES_SVH

`define SDIMB_MODE_W        13
`define SDIMB_MODE_RESET    13'h0000
`define SDIMB_BL_LSB        0
`define SDIMB_BL_MSB        2
`define SDIMB_ORDER_BIT     3
`define SDIMB_CL_LSB        4
`define SDIMB_CL_MSB        6
`define SDIMB_OPMODE_LSB    7
`define SDIMB_OPMODE_MSB    8
`define SDIMB_WBL_BIT       9
`define SDIMB_AUTO_PRE_BIT  10

`define SDIMB_BL_1          3'h0
`define SDIMB_BL_2          3'h1
`define SDIMB_BL_4          3'h2
`define SDIMB_BL_8          3'h3
`define SDIMB_BL_PAGE       3'h7
`define SDIMB_CL_2          3'h2
`define SDIMB_CL_3          3'h3
`define SDIMB_OPMODE_NORMAL 2'h0

`define SDIMB_COL_W         10
`define SDIMB_ROW_W         13
`define SDIMB_BANK_W        2
`define SDIMB_BANKS         4
`define SDIMB_LANES         4
`define SDIMB_DQ_W          64
`define SDIMB_REFRESH_NEED  2'h2

`endif

// *** src/sdimb_pkg.sv ***
// types shared by the synchronous dram command block
package sdimb_pkg;

	// command code is {chip select, row strobe, column strobe, write enable}, all active low
	typedef enum logic [3:0]
	{
		cmd_load_mode = 4'b0000,
		cmd_refresh   = 4'b0001,
		cmd_precharge = 4'b0010,
		cmd_active    = 4'b0011,
		cmd_write     = 4'b0100,
		cmd_read      = 4'b0101,
		cmd_terminate = 4'b0110,
		cmd_nop       = 4'b0111
	} sdimb_cmd_t;

	typedef enum logic
	{
		gen_idle = 1'b0,
		gen_run  = 1'b1
	} sdimb_gen_state_t;

endpackage

// *** src/sdimb_burst_if.sv ***
// burst column generator hookup between the command core and the generator
`timescale 1ns/1ps
`default_nettype none
`include "sdimb_defines.svh"

interface sdimb_burst_if;
	logic                    start;
	logic [`SDIMB_COL_W-1:0] start_col;
	logic [2:0]              len_code;
	logic                    interleave;
	logic                    single;
	logic                    stop;
	logic [`SDIMB_COL_W-1:0] col;
	logic                    beat;
	logic                    last;

	modport ctrl
	(
		output start, start_col, len_code, interleave, single, stop,
		input  col, beat, last
	);

	modport gen
	(
		input  start, start_col, len_code, interleave, single, stop,
		output col, beat, last
	);
endinterface

`default_nettype wire

// *** src/sdimb_burst_gen.sv ***
// burst column generator: wraps inside the aligned block, sequential or interleaved
`timescale 1ns/1ps
`default_nettype none
`include "sdimb_defines.svh"

module sdimb_burst_gen
	import sdimb_pkg::*;
(
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// burst control
	sdimb_burst_if.gen  bus
);

	sdimb_gen_state_t        state_r;
	logic [`SDIMB_COL_W-1:0] base_r;
	logic [`SDIMB_COL_W-1:0] cnt_r;
	logic [`SDIMB_COL_W-1:0] mask_r;
	logic                    inter_r;
	logic                    full_r;
	logic [`SDIMB_COL_W-1:0] offs;

	// size of the wrapping block less one; reserved codes behave as length one
	function automatic logic [`SDIMB_COL_W-1:0] burst_mask(input logic [2:0] code, input logic single);
		logic [`SDIMB_COL_W-1:0] m;
		m = '0;
		if (!single)
		begin
			case (code)
				`SDIMB_BL_2:    m = 10'h001;
				`SDIMB_BL_4:    m = 10'h003;
				`SDIMB_BL_8:    m = 10'h007;
				`SDIMB_BL_PAGE: m = 10'h3ff;
				default:        m = 10'h000;
			endcase
		end
		return m;
	endfunction

	assign offs = inter_r ? (base_r ^ cnt_r) : (base_r + cnt_r);
	assign bus.col  = (base_r & ~mask_r) | (offs & mask_r);
	assign bus.beat = (state_r == gen_run);
	// full page never ends on its own
	assign bus.last = (state_r == gen_run) && !full_r && (cnt_r == mask_r);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= gen_idle;
			base_r  <= '0;
			cnt_r   <= '0;
			mask_r  <= '0;
			inter_r <= 1'b0;
			full_r  <= 1'b0;
		end
		// a new column start is taken every cycle
		else if (bus.start)
		begin
			state_r <= gen_run;
			base_r  <= bus.start_col;
			cnt_r   <= '0;
			mask_r  <= burst_mask(bus.len_code, bus.single);
			full_r  <= (bus.len_code == `SDIMB_BL_PAGE) && !bus.single;
			inter_r <= bus.interleave && !((bus.len_code == `SDIMB_BL_PAGE) && !bus.single);
		end
		else if (state_r == gen_run)
		begin
			if (bus.stop || bus.last)
			begin
				state_r <= gen_idle;
			end
			else
			begin
				cnt_r <= cnt_r + 10'h001;
			end
		end
	end

endmodule

`default_nettype wire

// *** src/sdimb_top.sv ***
// synchronous dram device core: commands, bank rows, mode register, burst data path
//
// Summary of operation
// - all inputs are sampled on the rising clock edge only
// - access opens a row with ACTIVE, then READ or WRITE bursts
// - ACTIVE takes bank from the two bank lines, row from address 0-12
// - READ or WRITE takes the starting column from address 0-9
// - four banks per chip, 8192 rows by 1024 columns of 16 bits
// - one bank may precharge while another bank is accessed
// - column path accepts a new column every clock
// - auto precharge closes the row by itself when the burst reaches its last beat; a full page burst never does
// - precharge of every bank gives the all-banks-idle state
// - mode register is undefined until loaded; controller loads it first
// - mode register changes only on LOAD MODE REGISTER
// - mode layout: length 0-2, order 3, latency 4-6, mode 7-8, write 9
// - lengths 1,2,4,8 both orders; full page sequential only
// - burst length is the most columns per READ or WRITE
// - burst wraps inside aligned block of its length
// - full page wraps at row end; terminate gives arbitrary lengths
// - read latency is two or three clocks; drivers turn on one earlier
// - write-burst bit set makes writes single location
// - operating mode bits must be zero for normal operation
// - order bit picks sequential or interleaved
`timescale 1ns/1ps
`default_nettype none
`include "sdimb_defines.svh"

module sdimb_top
	import sdimb_pkg::*;
#(
	parameter int MEM_ROW_BITS = `SDIMB_ROW_W
)
(
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// per-lane command strobes, active low except clock enable and the byte masks
	input  wire logic [`SDIMB_LANES-1:0]    lane_cke_i,
	input  wire logic [`SDIMB_LANES-1:0]    lane_cs_n_i,
	input  wire logic [`SDIMB_LANES-1:0]    lane_ras_n_i,
	input  wire logic [`SDIMB_LANES-1:0]    lane_cas_n_i,
	input  wire logic [`SDIMB_LANES-1:0]    lane_we_n_i,
	input  wire logic [2*`SDIMB_LANES-1:0]  lane_dqm_i,
	// shared address and bank lines
	input  wire logic [`SDIMB_ROW_W-1:0]    addr_i,
	input  wire logic                       bank_select_low_i,
	input  wire logic                       bank_select_high_i,
	// data pins
	input  wire logic [`SDIMB_DQ_W-1:0]     dq_i,
	output logic      [`SDIMB_DQ_W-1:0]     dq_o,
	output logic      [2*`SDIMB_LANES-1:0]  dq_oe_n_o,
	// status
	output logic      [`SDIMB_BANKS-1:0]    bank_open_o,
	output logic                            all_banks_idle_o,
	output logic                            init_refresh_done_o,
	output logic                            mode_loaded_o,
	output logic      [`SDIMB_MODE_W-1:0]   operating_configuration_o
);

	localparam int IDX_W = `SDIMB_BANK_W + MEM_ROW_BITS + `SDIMB_COL_W;

	sdimb_burst_if burst ();

	// storage of every bank, row and column, 64 bits across four lanes
	logic [`SDIMB_DQ_W-1:0]    mem [0:(1<<IDX_W)-1];

	logic [`SDIMB_MODE_W-1:0]  operating_configuration_r;
	logic                      mode_loaded_r;
	logic [`SDIMB_BANKS-1:0]   bank_open_r;
	logic [`SDIMB_ROW_W-1:0]   open_row_r [0:`SDIMB_BANKS-1];
	logic [1:0]                refresh_cnt_r;
	logic [`SDIMB_BANK_W-1:0]  burst_bank_r;
	logic                      burst_write_r;
	logic                      burst_auto_pre_r;
	logic [`SDIMB_LANES-1:0]   burst_lanes_r;
	logic [`SDIMB_DQ_W-1:0]    wr_data_r;
	logic [2*`SDIMB_LANES-1:0] wr_mask_r;
	logic [2*`SDIMB_LANES-1:0] rd_mask_r;
	logic [`SDIMB_DQ_W-1:0]    rd_data0_r;
	logic                      rd_valid0_r;
	logic [`SDIMB_DQ_W-1:0]    dq_r;
	logic [2*`SDIMB_LANES-1:0] dq_oe_n_r;

	logic                      cmd_valid;
	sdimb_cmd_t                cmd;
	logic [`SDIMB_BANK_W-1:0]  bank_sel;
	logic                      is_read;
	logic                      is_write;
	logic                      latency3;
	logic [IDX_W-1:0]          beat_idx;
	logic                      rd_beat;
	logic                      wr_beat;
	logic [`SDIMB_DQ_W-1:0]    rd_word;
	logic [`SDIMB_ROW_W-1:0]   beat_row;
	logic [2*`SDIMB_LANES-1:0] wr_bytes;

	// one enable per byte from the per-lane selects
	function automatic logic [2*`SDIMB_LANES-1:0] lane_bytes(input logic [`SDIMB_LANES-1:0] l);
		logic [2*`SDIMB_LANES-1:0] b;
		b = '0;
		for (int i = 0; i < `SDIMB_LANES; i++)
		begin
			b[2*i]   = l[i];
			b[2*i+1] = l[i];
		end
		return b;
	endfunction

	// lane 0 carries the command, each lane its own select and masks
	// pins are only looked at through clocked processes below
	assign cmd_valid = lane_cke_i[0] && !lane_cs_n_i[0];
	assign cmd       = sdimb_cmd_t'({1'b0, lane_ras_n_i[0], lane_cas_n_i[0], lane_we_n_i[0]});
	assign bank_sel  = {bank_select_high_i, bank_select_low_i};
	assign is_read   = cmd_valid && (cmd == cmd_read);
	assign is_write  = cmd_valid && (cmd == cmd_write);
	// any code other than two runs at three
	assign latency3  = (operating_configuration_r[`SDIMB_CL_MSB:`SDIMB_CL_LSB] != `SDIMB_CL_2);

	// READ or WRITE starts a burst in the open row
	assign burst.start      = is_read || is_write;
	assign burst.start_col  = addr_i[`SDIMB_COL_W-1:0];
	assign burst.len_code   = operating_configuration_r[`SDIMB_BL_MSB:`SDIMB_BL_LSB];
	assign burst.interleave = operating_configuration_r[`SDIMB_ORDER_BIT];
	// write-burst bit limits writes to one location
	assign burst.single     = is_write && operating_configuration_r[`SDIMB_WBL_BIT];
	// terminate, or precharge of the burst's bank, ends the burst
	assign burst.stop = cmd_valid && ((cmd == cmd_terminate) ||
		((cmd == cmd_precharge) && (addr_i[`SDIMB_AUTO_PRE_BIT] || bank_sel == burst_bank_r)));

	sdimb_burst_gen u_burst_gen
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.bus   (burst.gen)
	);

	assign beat_row = open_row_r[burst_bank_r];
	assign beat_idx = {burst_bank_r, beat_row[MEM_ROW_BITS-1:0], burst.col};
	assign rd_beat  = burst.beat && !burst_write_r;
	assign wr_beat  = burst.beat && burst_write_r;
	assign rd_word  = mem[beat_idx];
	// bytes of selected lanes that the write mask leaves open
	assign wr_bytes = lane_bytes(burst_lanes_r) & ~wr_mask_r;

	// mode register written by LOAD MODE REGISTER only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// zero stands in for the undefined power-up contents
			operating_configuration_r <= `SDIMB_MODE_RESET;
			mode_loaded_r             <= 1'b0;
		end
		else if (cmd_valid && cmd == cmd_load_mode)
		begin
			// fields land at their bit positions
			operating_configuration_r <= addr_i[`SDIMB_MODE_W-1:0];
			mode_loaded_r             <= 1'b1;
		end
	end

	// bank open state and rows
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bank_open_r <= '0;
			for (int b = 0; b < `SDIMB_BANKS; b++)
			begin
				open_row_r[b] <= '0;
			end
		end
		else
		begin
			// self-timed close after the last beat
			if (burst.last && burst_auto_pre_r)
			begin
				bank_open_r[burst_bank_r] <= 1'b0;
			end
			if (cmd_valid && cmd == cmd_active)
			begin
				// bank and row taken with ACTIVE
				bank_open_r[bank_sel] <= 1'b1;
				open_row_r[bank_sel]  <= addr_i;
			end
			else if (cmd_valid && cmd == cmd_precharge)
			begin
				// all-bank precharge leaves every bank idle
				if (addr_i[`SDIMB_AUTO_PRE_BIT])
				begin
					bank_open_r <= '0;
				end
				// single-bank precharge leaves the others running
				else
				begin
					bank_open_r[bank_sel] <= 1'b0;
				end
			end
		end
	end

	// refreshes seen from the all-idle state, saturating at two
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			refresh_cnt_r <= 2'h0;
		end
		else if (cmd_valid && cmd == cmd_refresh && bank_open_r == '0 &&
			refresh_cnt_r != `SDIMB_REFRESH_NEED)
		begin
			refresh_cnt_r <= refresh_cnt_r + 2'h1;
		end
	end

	// burst context captured with READ or WRITE
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			burst_bank_r     <= '0;
			burst_write_r    <= 1'b0;
			burst_auto_pre_r <= 1'b0;
			burst_lanes_r    <= '0;
		end
		else if (burst.start)
		begin
			burst_bank_r     <= bank_sel;
			burst_write_r    <= is_write;
			burst_auto_pre_r <= addr_i[`SDIMB_AUTO_PRE_BIT];
			burst_lanes_r    <= lane_cke_i & ~lane_cs_n_i;
		end
	end

	// write data and masks sampled every edge, stored one cycle later
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_data_r <= '0;
			wr_mask_r <= '1;
			rd_mask_r <= '1;
		end
		else
		begin
			wr_data_r <= dq_i;
			wr_mask_r <= lane_dqm_i;
			rd_mask_r <= lane_dqm_i;
		end
	end

	// one column per clock into the array
	always_ff @(posedge clk_i)
	begin
		if (wr_beat)
		begin
			for (int i = 0; i < 2*`SDIMB_LANES; i++)
			begin
				if (wr_bytes[i])
				begin
					mem[beat_idx][8*i +: 8] <= wr_data_r[8*i +: 8];
				end
			end
		end
	end

	// read pipeline, drivers on one edge before data is due
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rd_data0_r  <= '0;
			rd_valid0_r <= 1'b0;
			dq_r        <= '0;
			dq_oe_n_r   <= '1;
		end
		else
		begin
			rd_data0_r  <= rd_word;
			rd_valid0_r <= rd_beat;
			dq_r        <= latency3 ? rd_data0_r : rd_word;
			dq_oe_n_r   <= ~({2*`SDIMB_LANES{latency3 ? rd_valid0_r : rd_beat}} &
				lane_bytes(burst_lanes_r) & ~rd_mask_r);
		end
	end

	assign dq_o                      = dq_r;
	assign dq_oe_n_o                 = dq_oe_n_r;
	assign bank_open_o               = bank_open_r;
	assign all_banks_idle_o          = (bank_open_r == '0);
	assign init_refresh_done_o       = (refresh_cnt_r == `SDIMB_REFRESH_NEED);
	assign mode_loaded_o             = mode_loaded_r;
	// operating mode bits are shown but only normal mode is modelled
	assign operating_configuration_o = operating_configuration_r;

endmodule

`default_nettype wire

// *** tb/sdimb_top_assertions.sv ***
// property checker for the synchronous dram command block
`timescale 1ns/1ps
`default_nettype none

module sdimb_top_assertions
	import sdimb_pkg::*;
(
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// command side
	input wire logic [3:0]  lane_cke_i,
	input wire logic [3:0]  lane_cs_n_i,
	input wire logic [3:0]  lane_ras_n_i,
	input wire logic [3:0]  lane_cas_n_i,
	input wire logic [3:0]  lane_we_n_i,
	input wire logic [7:0]  lane_dqm_i,
	input wire logic [12:0] addr_i,
	input wire logic        bank_select_low_i,
	input wire logic        bank_select_high_i,
	// device outputs
	input wire logic [7:0]  dq_oe_n_o,
	input wire logic [3:0]  bank_open_o,
	input wire logic        all_banks_idle_o,
	input wire logic        init_refresh_done_o,
	input wire logic        mode_loaded_o,
	input wire logic [12:0] operating_configuration_o
);
	logic       take;
	logic [2:0] code;
	logic [1:0] bank;
	logic       rd_ok;

	assign take  = lane_cke_i[0] && !lane_cs_n_i[0];
	assign code  = {lane_ras_n_i[0], lane_cas_n_i[0], lane_we_n_i[0]};
	assign bank  = {bank_select_high_i, bank_select_low_i};
	assign rd_ok = take && code == 3'h5 && lane_dqm_i == 8'h00 && lane_cs_n_i == 4'h0;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_mode_load_value:
		assert property (take && code == 3'h0 |=> operating_configuration_o == $past(addr_i) && mode_loaded_o)
		else $error("mode register does not hold the loaded value");
	a_mode_hold_stable:
		assert property (!(take && code == 3'h0) |=> $stable(operating_configuration_o))
		else $error("mode register changed without a load");
	a_loaded_flag_holds:
		assert property (mode_loaded_o |=> mode_loaded_o)
		else $error("mode loaded flag dropped");
	a_active_opens_bank:
		assert property (take && code == 3'h3 |=> bank_open_o[$past(bank)])
		else $error("active did not open the addressed bank");
	a_active_keeps_others:
		assert property (take && code == 3'h3 |=> (bank_open_o & $past(bank_open_o)) == $past(bank_open_o))
		else $error("active closed another bank");
	a_precharge_all_idle:
		assert property (take && code == 3'h2 && addr_i[10] |=> all_banks_idle_o && bank_open_o == 4'h0)
		else $error("precharge of all banks did not give idle");
	a_refresh_flag_cause:
		assert property ($rose(init_refresh_done_o) |-> $past(take && code == 3'h1))
		else $error("refresh flag rose without a refresh");
	a_read_lat_two:
		assert property (rd_ok && operating_configuration_o[6:4] == 3'h2 |-> ##2 dq_oe_n_o == 8'h00)
		else $error("read data not driven after two clocks");
	a_read_lat_three:
		assert property (rd_ok && operating_configuration_o[6:4] == 3'h3 |-> ##3 dq_oe_n_o == 8'h00)
		else $error("read data not driven after three clocks");

	c_mode_load: cover property (take && code == 3'h0);
	c_read_two: cover property (rd_ok && operating_configuration_o[6:4] == 3'h2);
	c_auto_pre: cover property (take && code == 3'h5 && addr_i[10]);
	c_terminate: cover property (take && code == 3'h6);
endmodule

bind sdimb_top sdimb_top_assertions i_sdimb_top_assertions
(
	.clk_i                     (clk_i),
	.rst_i                     (rst_i),
	.lane_cke_i                (lane_cke_i),
	.lane_cs_n_i               (lane_cs_n_i),
	.lane_ras_n_i              (lane_ras_n_i),
	.lane_cas_n_i              (lane_cas_n_i),
	.lane_we_n_i               (lane_we_n_i),
	.lane_dqm_i                (lane_dqm_i),
	.addr_i                    (addr_i),
	.bank_select_low_i         (bank_select_low_i),
	.bank_select_high_i        (bank_select_high_i),
	.dq_oe_n_o                 (dq_oe_n_o),
	.bank_open_o               (bank_open_o),
	.all_banks_idle_o          (all_banks_idle_o),
	.init_refresh_done_o       (init_refresh_done_o),
	.mode_loaded_o             (mode_loaded_o),
	.operating_configuration_o (operating_configuration_o)
);

`default_nettype wire

// *** tb/sdimb_ctrl_model.sv ***
// memory controller model that issues commands to the dram device
`timescale 1ns/1ps
`default_nettype none

module sdimb_ctrl_model
	import sdimb_pkg::*;
#(
	parameter int WAIT_CYCLES = 4000
)
(
	// clock
	input  wire logic        clk_i,
	// command and data lines
	output logic      [3:0]  cke_o,
	output logic      [3:0]  cs_n_o,
	output logic      [3:0]  ras_n_o,
	output logic      [3:0]  cas_n_o,
	output logic      [3:0]  we_n_o,
	output logic      [7:0]  dqm_o,
	output logic      [12:0] addr_o,
	output logic      [1:0]  bank_o,
	output logic      [63:0] dq_o
);
	initial
	begin
		cke_o   = 4'hf;
		cs_n_o  = 4'hf;
		ras_n_o = 4'hf;
		cas_n_o = 4'hf;
		we_n_o  = 4'hf;
		dqm_o   = 8'h00;
		addr_o  = 13'h0000;
		bank_o  = 2'h0;
		dq_o    = 64'h0;
	end

	// one command for one clock, then nop with the data line inverted
	task cmd(input sdimb_cmd_t c, input logic [1:0] b, input logic [12:0] a, input logic [63:0] d);
		@(posedge clk_i);
		cs_n_o  <= {4{c[3]}};
		ras_n_o <= {4{c[2]}};
		cas_n_o <= {4{c[1]}};
		we_n_o  <= {4{c[0]}};
		bank_o  <= b;
		addr_o  <= a;
		dq_o    <= d;
		@(posedge clk_i);
		ras_n_o <= 4'hf;
		cas_n_o <= 4'hf;
		we_n_o  <= 4'hf;
		dq_o    <= ~d;
	endtask

	task power_up(input logic [12:0] mode);
		@(posedge clk_i);
		cs_n_o <= 4'h0;
		repeat (WAIT_CYCLES) @(posedge clk_i);
		cmd(cmd_precharge, 2'h0, 13'h0400, 64'h0);
		cmd(cmd_refresh, 2'h0, 13'h0000, 64'h0);
		cmd(cmd_refresh, 2'h0, 13'h0000, 64'h0);
		cmd(cmd_load_mode, 2'h0, {1'b0, mode[11:0]}, 64'h0);
		repeat (2) @(posedge clk_i);
	endtask
endmodule

`default_nettype wire

// *** tb/sdimb_top_bench.sv ***
// self-checking bench for the synchronous dram command block
`timescale 1ns/1ps
`default_nettype none

module sdimb_top_bench
	import sdimb_pkg::*;
();
	localparam logic [63:0] D0 = 64'h0123_4567_89ab_cdef;
	localparam logic [63:0] D1 = 64'hfeed_0000_1111_2222;
	localparam logic [63:0] D2 = 64'h5a5a_3c3c_a5a5_c3c3;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [3:0]  cke, cs_n, ras_n, cas_n, we_n, open;
	logic [7:0]  dqm, oe_n;
	logic [12:0] addr, mode;
	logic [1:0]  bank;
	logic [63:0] wdata, rdata;
	logic        idle, refd, loaded;
	logic [63:0] exp_q [4];
	int          err_count = 0;
	int          samples_checked = 0;

	always #12.5 clk_i = ~clk_i;

	sdimb_ctrl_model i_sdimb_ctrl_model
	(
		.clk_i (clk_i), .cke_o (cke), .cs_n_o (cs_n), .ras_n_o (ras_n), .cas_n_o (cas_n),
		.we_n_o (we_n), .dqm_o (dqm), .addr_o (addr), .bank_o (bank), .dq_o (wdata)
	);

	sdimb_top #(.MEM_ROW_BITS(4)) i_sdimb_top
	(
		.clk_i (clk_i), .rst_i (rst_i), .lane_cke_i (cke), .lane_cs_n_i (cs_n),
		.lane_ras_n_i (ras_n), .lane_cas_n_i (cas_n), .lane_we_n_i (we_n), .lane_dqm_i (dqm),
		.addr_i (addr), .bank_select_low_i (bank[0]), .bank_select_high_i (bank[1]),
		.dq_i (wdata), .dq_o (rdata), .dq_oe_n_o (oe_n), .bank_open_o (open),
		.all_banks_idle_o (idle), .init_refresh_done_o (refd), .mode_loaded_o (loaded),
		.operating_configuration_o (mode)
	);

	task check(input logic [63:0] s, input logic [63:0] e);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// read burst and compare each beat against exp_q
	task rd(input logic [1:0] b, input logic [12:0] a, input int l, input int n);
		i_sdimb_ctrl_model.cmd(cmd_read, b, a, 64'h0);
		repeat (l - 1) @(posedge clk_i);
		for (int k = 0; k < n; k++)
		begin
			#1;
			check(rdata, exp_q[k]);
			@(posedge clk_i);
		end
		#1;
		check({56'h0, oe_n}, 64'hff);
	endtask

	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		i_sdimb_ctrl_model.power_up(13'h0021);
		check({63'h0, refd}, 64'h1);
		check({63'h0, idle}, 64'h1);
		check({63'h0, loaded}, 64'h1);
		check({51'h0, mode}, 64'h21);
		i_sdimb_ctrl_model.cmd(cmd_active, 2'h2, 13'h0005, 64'h0);
		i_sdimb_ctrl_model.cmd(cmd_active, 2'h0, 13'h0003, 64'h0);
		#1;
		check({60'h0, open}, 64'h5);
		i_sdimb_ctrl_model.cmd(cmd_write, 2'h2, 13'h0005, D0);
		exp_q = '{D0, ~D0, 64'h0, 64'h0};
		rd(2'h2, 13'h0005, 2, 2);
		exp_q = '{~D0, D0, 64'h0, 64'h0};
		rd(2'h2, 13'h0004, 2, 2);
		i_sdimb_ctrl_model.cmd(cmd_precharge, 2'h0, 13'h0400, 64'h0);
		#1;
		check({63'h0, idle}, 64'h1);
		i_sdimb_ctrl_model.cmd(cmd_load_mode, 2'h0, 13'h023a, 64'h0);
		i_sdimb_ctrl_model.cmd(cmd_active, 2'h2, 13'h0005, 64'h0);
		i_sdimb_ctrl_model.cmd(cmd_write, 2'h2, 13'h0007, D2);
		i_sdimb_ctrl_model.cmd(cmd_write, 2'h2, 13'h0006, D1);
		exp_q = '{D0, ~D0, D2, D1};
		rd(2'h2, 13'h0405, 3, 4);
		repeat (4) @(posedge clk_i);
		#1;
		check({60'h0, open}, 64'h0);
		// full page wraps at row end, terminate stops it
		i_sdimb_ctrl_model.cmd(cmd_load_mode, 2'h0, 13'h0027, 64'h0);
		i_sdimb_ctrl_model.cmd(cmd_active, 2'h1, 13'h0003, 64'h0);
		i_sdimb_ctrl_model.cmd(cmd_write, 2'h1, 13'h0001, D0);
		i_sdimb_ctrl_model.cmd(cmd_terminate, 2'h0, 13'h0000, D2);
		i_sdimb_ctrl_model.cmd(cmd_write, 2'h1, 13'h03ff, D1);
		i_sdimb_ctrl_model.cmd(cmd_terminate, 2'h0, 13'h0000, D2);
		i_sdimb_ctrl_model.cmd(cmd_precharge, 2'h1, 13'h0000, 64'h0);
		i_sdimb_ctrl_model.cmd(cmd_load_mode, 2'h0, 13'h0021, 64'h0);
		i_sdimb_ctrl_model.cmd(cmd_active, 2'h1, 13'h0003, 64'h0);
		exp_q = '{~D1, D0, 64'h0, 64'h0};
		rd(2'h1, 13'h0000, 2, 2);
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		complete_run();
	end
endmodule

`default_nettype wire
